// ===== verilog/atx_audio_ctrl.v
// audio transmitter input control: rate, format, mode, clocks
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "atx_defines.vh"

module atx_audio_ctrl #(
   parameter TIMEOUT_CYC = `ATX_TIMEOUT_CYC
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [6:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr_en,
   input  wire        rd_en,
   output reg  [7:0]  rdata_r,
   input  wire        ws_i,
   output reg         ws_o_r,
   output reg         ws_oe_n_r,
   output reg         bclk_o_r,
   output reg         bclk_oe_n_r,
   input  wire        spdif_frame_i,
   input  wire        port_pin1_i,
   input  wire [2:0]  direct_data_i,
   input  wire        ssel_i,
   output reg         mclk_o_r,
   output reg         rf_en_o_r,
   output reg         tx_pd_o_r,
   output reg         spdif_sel_o_r,
   output reg  [2:0]  direct_data_o_r,
   output reg         wake_o_r,
   output reg         reconfig_o_r,
   output reg  [1:0]  act_scale_o_r,
   output reg  [1:0]  act_fund_o_r,
   output reg         comp_en_o_r,
   input  wire [23:0] samp_i,
   input  wire        samp_vld_i,
   input  wire        pkt_start_i,
   input  wire [23:0] pkt_peak_i,
   output reg  [15:0] samp_o_r,
   output reg         samp_vld_o_r,
   output reg  [3:0]  shift_o_r
);

   localparam NSYNC = 7;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   reg  [7:0]       rate_r;
   reg              fmt_r;
   reg  [7:0]       mode_r;
   reg  [7:0]       sai_r;
   reg  [7:0]       link_r;
   reg              act_auto_r;
   reg  [1:0]       usr_scale_r;
   reg  [1:0]       usr_fund_r;
   reg  [NSYNC-1:0] s1_r;
   reg  [NSYNC-1:0] s2_r;
   reg              pin1_prev_r;
   reg  [24:0]      mclk_acc_r;
   reg  [24:0]      bclk_acc_r;
   reg  [4:0]       bit_cnt_r;
   reg  [3:0]       shift_r;
   wire [NSYNC-1:0] raw_w;
   wire [1:0]       det_scale_w;
   wire [1:0]       det_fund_w;
   wire             det_src_w;
   wire             pin1_chg_w;
   wire             master_w;
   wire             spdif_w;
   reg  [23:0]      mclk_inc_w;
   reg  [23:0]      bclk_inc_w;
   reg  [3:0]       shift_use_w;
   reg  [23:0]      shifted_w;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // phase step for 256 x the given fundamental
   function [23:0] fund_inc;
      input [1:0] f;
      begin
         if (f == `ATX_FUND_48)
            fund_inc = `ATX_INC_256X48;
         else if (f == `ATX_FUND_44)
            fund_inc = `ATX_INC_256X44;
         else if (f == `ATX_FUND_32)
            fund_inc = `ATX_INC_256X32;
         else
            fund_inc = 24'h000000;
      end
   endfunction

   // fewest LSBs to drop so the packet peak fits 16 bits
   function [3:0] drop_bits;
      input [23:0] peak;
      integer k;
      begin
         drop_bits = 4'h8;
         for (k = 7; k >= 0; k = k - 1)
            if (peak < (24'h008000 << k))
               drop_bits = k[3:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers, two flops per input
   // ----------------------------------------------------------------
   assign raw_w = {ws_i, spdif_frame_i, port_pin1_i, ssel_i, direct_data_i};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1)
      begin : g_sync
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_r[gi] <= 1'b0;
               s2_r[gi] <= 1'b0;
            end
            else
            begin
               s1_r[gi] <= raw_w[gi];
               s2_r[gi] <= s1_r[gi];
            end
         end
      end
   endgenerate

   assign master_w   = sai_r[`ATX_SAI_MASTER];
   assign spdif_w    = mode_r[`ATX_MODE_SPDIF];
   assign pin1_chg_w = s2_r[4] ^ pin1_prev_r;
   // S/PDIF mode feeds the framing to detection; serial uses word select
   assign det_src_w  = spdif_w ? s2_r[5] : s2_r[6];

   // ----------------------------------------------------------------
   // rate detector
   // ----------------------------------------------------------------
   atx_rate_detect #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_det (
      .clk     (clk),
      .rst_n   (rst_n),
      .src_i   (det_src_w),
      .scale_r (det_scale_w),
      .fund_r  (det_fund_w)
   );

   // ----------------------------------------------------------------
   // register writes and reconfigure pulse
   // ----------------------------------------------------------------
   // wake clears power down after any write in the same cycle
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rate_r       <= `ATX_RST_RATE;
         fmt_r        <= 1'b0;
         mode_r       <= `ATX_RST_MODE;
         sai_r        <= `ATX_RST_SAI;
         link_r       <= `ATX_RST_LINK;
         reconfig_o_r <= 1'b0;
         wake_o_r     <= 1'b0;
         pin1_prev_r  <= 1'b0;
      end
      else
      begin
         reconfig_o_r <= 1'b0;
         pin1_prev_r  <= s2_r[4];
         if (wr_en)
         begin
            if (addr == `ATX_ADDR_RATE)
               rate_r <= {1'b0, wdata[6:3], 2'b00, wdata[0]};
            else if (addr == `ATX_ADDR_FMT)
               fmt_r <= wdata[0];
            else if (addr == `ATX_ADDR_MODE)
               mode_r <= {wdata[7:5], 1'b0, wdata[3:0]};
            else if (addr == `ATX_ADDR_SAI_CFG)
               sai_r <= {wdata[7], 1'b0, wdata[5:0]};
            else if (addr == `ATX_ADDR_LINK)
            begin
               link_r       <= {wdata[7:5], 1'b0, wdata[3:0]};
               reconfig_o_r <= wdata[`ATX_LINK_RECONFIG];
            end
         end
         wake_o_r <= pin1_chg_w & mode_r[`ATX_MODE_WAKE_EN] & mode_r[`ATX_MODE_PD];
         if (pin1_chg_w & mode_r[`ATX_MODE_WAKE_EN])
            mode_r[`ATX_MODE_PD] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // active settings; user values loaded only by reconfigure
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act_auto_r  <= 1'b0;
         usr_scale_r <= `ATX_SCALE_QTR;
         usr_fund_r  <= `ATX_FUND_48;
         comp_en_o_r <= 1'b0;
      end
      else if (reconfig_o_r)
      begin
         act_auto_r  <= rate_r[`ATX_RATE_AUTO];
         usr_scale_r <= rate_r[`ATX_RATE_SCALE_LO+1:`ATX_RATE_SCALE_LO];
         usr_fund_r  <= rate_r[`ATX_RATE_FUND_LO+1:`ATX_RATE_FUND_LO];
         comp_en_o_r <= fmt_r;
      end
   end

   // auto follows the detector in slave mode only; S/PDIF is detected regardless
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act_scale_o_r <= `ATX_SCALE_QTR;
         act_fund_o_r  <= `ATX_FUND_48;
      end
      else if ((act_auto_r & ~master_w) | spdif_w)
      begin
         act_scale_o_r <= spdif_w ? `ATX_SCALE_ONE : det_scale_w;
         act_fund_o_r  <= det_fund_w;
      end
      else
      begin
         act_scale_o_r <= usr_scale_r;
         act_fund_o_r  <= usr_fund_r;
      end
   end

   // ----------------------------------------------------------------
   // register reads, data valid the cycle after the strobe
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 8'h00;
      else if (!rd_en)
         rdata_r <= 8'h00;
      else if (addr == `ATX_ADDR_RATE)
         rdata_r <= rate_r[`ATX_RATE_AUTO] ?
                    {1'b0, det_scale_w, det_fund_w, 2'b00, 1'b1} :
                    rate_r;
      else if (addr == `ATX_ADDR_FMT)
         rdata_r <= {7'h00, fmt_r};
      else if (addr == `ATX_ADDR_MODE)
         rdata_r <= mode_r;
      else if (addr == `ATX_ADDR_SAI_CFG)
         rdata_r <= sai_r;
      else if (addr == `ATX_ADDR_LINK)
         rdata_r <= link_r;
      else
         rdata_r <= 8'h00;
   end

   // ----------------------------------------------------------------
   // mode outputs and direct data
   // ----------------------------------------------------------------
   // top direct data pin only exists with the interface select high
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rf_en_o_r       <= 1'b0;
         tx_pd_o_r       <= 1'b0;
         spdif_sel_o_r   <= 1'b0;
         direct_data_o_r <= 3'b000;
      end
      else
      begin
         rf_en_o_r     <= mode_r[`ATX_MODE_RF_EN];
         tx_pd_o_r     <= mode_r[`ATX_MODE_PD];
         spdif_sel_o_r <= spdif_w;
         if (mode_r[`ATX_MODE_DD_EN])
            direct_data_o_r <= {s2_r[2] & s2_r[3], s2_r[1:0]};
         else
            direct_data_o_r <= 3'b000;
      end
   end

   // ----------------------------------------------------------------
   // clock synthesis: phase accumulators, jitter of one 25 ns cycle
   // ----------------------------------------------------------------
   always @*
   begin
      mclk_inc_w = 24'h000000;
      if (mode_r[1:0] != 2'b00)
         mclk_inc_w = fund_inc(mode_r[1:0] - 2'b01);
      // bit clock is 64 fs: 256 fs step over 4, 8 or 16
      bclk_inc_w = 24'h000000;
      if (act_scale_o_r == `ATX_SCALE_ONE)
         bclk_inc_w = fund_inc(act_fund_o_r) >> 2;
      else if (act_scale_o_r == `ATX_SCALE_HALF)
         bclk_inc_w = fund_inc(act_fund_o_r) >> 3;
      else if (act_scale_o_r == `ATX_SCALE_QTR)
         bclk_inc_w = fund_inc(act_fund_o_r) >> 4;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mclk_acc_r <= 25'h0000000;
         mclk_o_r   <= 1'b0;
      end
      else if (spdif_w | (mode_r[1:0] == 2'b00) | mode_r[`ATX_MODE_PD])
      begin
         mclk_acc_r <= 25'h0000000;
         mclk_o_r   <= 1'b0;
      end
      else
      begin
         mclk_acc_r <= {1'b0, mclk_acc_r[23:0]} + {1'b0, mclk_inc_w};
         if (mclk_acc_r[24])
            mclk_o_r <= ~mclk_o_r;
      end
   end

   // master mode outside S/PDIF drives word select and bit clock, 32 bits per half
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bclk_acc_r  <= 25'h0000000;
         bit_cnt_r   <= 5'h00;
         bclk_o_r    <= 1'b0;
         ws_o_r      <= 1'b0;
         bclk_oe_n_r <= 1'b1;
         ws_oe_n_r   <= 1'b1;
      end
      else
      begin
         bclk_oe_n_r <= ~(master_w & ~spdif_w);
         ws_oe_n_r   <= ~(master_w & ~spdif_w);
         if (!master_w | spdif_w)
         begin
            bclk_acc_r <= 25'h0000000;
            bit_cnt_r  <= 5'h00;
            bclk_o_r   <= 1'b0;
            ws_o_r     <= 1'b0;
         end
         else
         begin
            bclk_acc_r <= {1'b0, bclk_acc_r[23:0]} + {1'b0, bclk_inc_w};
            if (bclk_acc_r[24])
            begin
               bclk_o_r <= ~bclk_o_r;
               // word select moves on the falling bit clock edge
               if (bclk_o_r)
               begin
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == 5'h1f)
                     ws_o_r <= ~ws_o_r;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // sample path: linear top 16 bits or per-packet truncation
   // ----------------------------------------------------------------
   always @*
   begin
      shift_use_w = pkt_start_i ? drop_bits(pkt_peak_i) : shift_r;
      shifted_w   = samp_i;
      if (comp_en_o_r)
         shifted_w = $signed(samp_i) >>> shift_use_w;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_r      <= 4'h0;
         shift_o_r    <= 4'h0;
         samp_o_r     <= 16'h0000;
         samp_vld_o_r <= 1'b0;
      end
      else
      begin
         if (pkt_start_i)
            shift_r <= shift_use_w;
         samp_vld_o_r <= samp_vld_i;
         if (samp_vld_i)
         begin
            shift_o_r <= comp_en_o_r ? shift_use_w : 4'h0;
            samp_o_r  <= comp_en_o_r ? shifted_w[15:0] : samp_i[23:8];
         end
      end
   end

endmodule
`default_nettype wire

// ===== common/atx_defines.vh
// constants for the audio transmitter input control block
`ifndef ATX_DEFINES_VH
`define ATX_DEFINES_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ATX_ADDR_RATE      7'h01
`define ATX_ADDR_FMT       7'h51
`define ATX_ADDR_SAI_CFG   7'h54
`define ATX_ADDR_MODE      7'h5a
`define ATX_ADDR_LINK      7'h60

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATX_RATE_AUTO      0
`define ATX_RATE_FUND_LO   3
`define ATX_RATE_SCALE_LO  5
`define ATX_LINK_RECONFIG  4
`define ATX_SAI_MASTER     7
`define ATX_MODE_RF_EN     7
`define ATX_MODE_PD        6
`define ATX_MODE_WAKE_EN   5
`define ATX_MODE_DD_EN     3
`define ATX_MODE_SPDIF     2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ATX_RST_RATE       8'h00
`define ATX_RST_FMT        8'h00
`define ATX_RST_MODE       8'h00
`define ATX_RST_SAI        8'h00
`define ATX_RST_LINK       8'h00

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define ATX_FUND_48        2'b00
`define ATX_FUND_44        2'b01
`define ATX_FUND_32        2'b10
`define ATX_FUND_NONE      2'b11
`define ATX_SCALE_QTR      2'b00
`define ATX_SCALE_HALF     2'b01
`define ATX_SCALE_ONE      2'b10

// ----------------------------------------------------------------
// clock synthesis: 24-bit phase steps at 40 MHz, toggle per wrap
// ----------------------------------------------------------------
`define ATX_INC_256X48     24'h9d4952
`define ATX_INC_256X44     24'h9081d3
`define ATX_INC_256X32     24'h68db8c

// ----------------------------------------------------------------
// frame period upper bounds in 40 MHz cycles (midpoints of rates)
// ----------------------------------------------------------------
`define ATX_LIM_48K        14'd870
`define ATX_LIM_44K        14'd1078
`define ATX_LIM_32K        14'd1458
`define ATX_LIM_24K        14'd1740
`define ATX_LIM_22K        14'd2157
`define ATX_LIM_16K        14'd2916
`define ATX_LIM_12K        14'd3480
`define ATX_LIM_11K        14'd4314
`define ATX_LIM_8K         14'd5500
`define ATX_TIMEOUT_CYC    8192

`endif

// ===== verilog/atx_rate_detect.v
// frame period measurement and sample rate classification
`timescale 1ns/1ps
`default_nettype none
`include "atx_defines.vh"

module atx_rate_detect #(
   parameter TIMEOUT_CYC = `ATX_TIMEOUT_CYC
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       src_i,
   output reg  [1:0] scale_r,
   output reg  [1:0] fund_r
);

   reg  [13:0] cnt_r;
   reg         prev_r;
   wire        edge_w;
   reg  [3:0]  cls_w;

   // ----------------------------------------------------------------
   // classify: {scale, fundamental} from one frame period
   // ----------------------------------------------------------------
   function [3:0] classify;
      input [13:0] p;
      begin
         if (p < `ATX_LIM_48K)
            classify = {`ATX_SCALE_ONE, `ATX_FUND_48};
         else if (p < `ATX_LIM_44K)
            classify = {`ATX_SCALE_ONE, `ATX_FUND_44};
         else if (p < `ATX_LIM_32K)
            classify = {`ATX_SCALE_ONE, `ATX_FUND_32};
         else if (p < `ATX_LIM_24K)
            classify = {`ATX_SCALE_HALF, `ATX_FUND_48};
         else if (p < `ATX_LIM_22K)
            classify = {`ATX_SCALE_HALF, `ATX_FUND_44};
         else if (p < `ATX_LIM_16K)
            classify = {`ATX_SCALE_HALF, `ATX_FUND_32};
         else if (p < `ATX_LIM_12K)
            classify = {`ATX_SCALE_QTR, `ATX_FUND_48};
         else if (p < `ATX_LIM_11K)
            classify = {`ATX_SCALE_QTR, `ATX_FUND_44};
         else if (p < `ATX_LIM_8K)
            classify = {`ATX_SCALE_QTR, `ATX_FUND_32};
         else
            classify = {`ATX_SCALE_ONE, `ATX_FUND_NONE};
      end
   endfunction

   assign edge_w = src_i & ~prev_r;

   // one rising frame edge per sample period
   always @*
   begin
      cls_w = classify(cnt_r);
   end

   // ----------------------------------------------------------------
   // period counter; a stalled source reads as no input
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r   <= 14'h0000;
         prev_r  <= 1'b0;
         scale_r <= `ATX_SCALE_ONE;
         fund_r  <= `ATX_FUND_NONE;
      end
      else
      begin
         prev_r <= src_i;
         if (edge_w)
         begin
            cnt_r   <= 14'h0001;
            scale_r <= cls_w[3:2];
            // first edge after silence carries no real period
            fund_r  <= (cnt_r >= TIMEOUT_CYC[13:0]) ? `ATX_FUND_NONE : cls_w[1:0];
         end
         else if (cnt_r >= TIMEOUT_CYC[13:0])
         begin
            fund_r <= `ATX_FUND_NONE;
         end
         else
         begin
            cnt_r <= cnt_r + 14'h0001;
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/atx_src_model.sv
// behavioural serial audio source that drives word select in slave mode
`timescale 1ns/1ps
`default_nettype none
module atx_src_model (
   input  wire logic [7:0] half_bits,
   input  wire logic       spdif_on,
   output logic            ws_o,
   output logic            frame_o
);
   logic bclk = 1'b0;
   int   cnt  = 0;
   initial ws_o = 1'b0;
   initial frame_o = 1'b0;
   // S/PDIF frame level, 912-cycle period, still while off
   always #11400 frame_o = spdif_on & ~frame_o;
   // 200 ns bit clock, stands still while no rate is set
   always #100 bclk = (half_bits != 8'h00) ? ~bclk : 1'b0;
   // word select toggles every half_bits falling bit clock edges
   always @(negedge bclk)
   begin
      cnt = cnt + 1;
      if (cnt >= half_bits)
      begin
         cnt  = 0;
         ws_o = ~ws_o;
      end
   end
endmodule
`default_nettype wire

// ===== tb/atx_audio_ctrl_chk.sv
// port-level assertions for the audio input control block
`timescale 1ns/1ps
`default_nettype none
module atx_audio_ctrl_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [6:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  rdata_r,
   input wire logic [23:0] samp_i,
   input wire logic        samp_vld_i,
   input wire logic        pkt_start_i,
   input wire logic [23:0] pkt_peak_i,
   input wire logic [15:0] samp_o_r,
   input wire logic        samp_vld_o_r,
   input wire logic [3:0]  shift_o_r,
   input wire logic        comp_en_o_r,
   input wire logic        reconfig_o_r,
   input wire logic        rf_en_o_r,
   input wire logic        spdif_sel_o_r,
   input wire logic        tx_pd_o_r,
   input wire logic        mclk_o_r,
   input wire logic        wake_o_r,
   input wire logic        ws_oe_n_r,
   input wire logic        bclk_oe_n_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // least drop count that keeps the packet peak inside 16 bits
   function automatic logic [3:0] sh(input logic [23:0] p);
      for (int k = 0; k < 8; k++)
         if (p < (24'h008000 << k))
            return 4'(k);
      return 4'h8;
   endfunction
   a_rd_idle: assert property (!$past(rd_en) |-> rdata_r == 8'h00)
      else $error("read data not idle");
   a_reconf_go: assert property (wr_en && addr == 7'h60 && wdata[4] |=> reconfig_o_r)
      else $error("no reconfigure pulse");
   a_reconf_one: assert property (reconfig_o_r |=> !reconfig_o_r)
      else $error("reconfigure pulse too long");
   a_mode_out: assert property (wr_en && addr == 7'h5a |-> ##2 rf_en_o_r == $past(wdata[7], 2)
      && spdif_sel_o_r == $past(wdata[2], 2))
      else $error("mode outputs wrong");
   a_spdif_mclk: assert property (spdif_sel_o_r [*3] |-> !mclk_o_r)
      else $error("master clock runs with spdif");
   a_pd_mclk: assert property (tx_pd_o_r [*3] |-> !mclk_o_r)
      else $error("master clock runs in power down");
   a_pass_thru: assert property (samp_vld_i && !comp_en_o_r |=> samp_vld_o_r
      && shift_o_r == 4'h0 && {8'h00, samp_o_r} == ($past(samp_i) >> 8))
      else $error("uncompressed sample wrong");
   a_comp_shift: assert property (samp_vld_i && pkt_start_i && comp_en_o_r
      |=> shift_o_r == sh($past(pkt_peak_i)))
      else $error("drop count wrong");
   a_wake_clear: assert property (wake_o_r |-> ##[0:2] !tx_pd_o_r)
      else $error("wake left power down");
   a_oe_pair: assert property (bclk_oe_n_r == ws_oe_n_r)
      else $error("clock enables differ");
endmodule
bind atx_audio_ctrl atx_audio_ctrl_chk u_atx_audio_ctrl_chk (.*);
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the audio input control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst_n, wr_en, rd_en, samp_vld_i, pkt_start_i, port_pin1_i, ssel_i;
   logic        ws_i, mclk, rf_en, tx_pd, spdif_sel, wake, reconf, comp_en, s_vld, boe, pm;
   logic        woe, bck, wso, spf, spf_on = 1'b0;
   logic [6:0]  addr;
   logic [7:0]  wdata, rdata_r, half, d;
   logic [23:0] samp_i, pkt_peak_i, s, pk;
   logic [2:0]  direct_data_i, dd_o;
   logic [1:0]  a_sc, a_fd, sc, psc, pf;
   logic [15:0] s_o, e;
   logic [3:0]  sh_o;
   logic [31:0] x = 32'd44;
   int          num_errors = 0, n_checks = 0, cyc = 0, n, k;
   int          ex[4] = '{0, 614, 564, 409};
   int          hv[3] = '{52, 57, 0};
   int          fv[3] = '{0, 1, 3};

   atx_audio_ctrl #(.TIMEOUT_CYC(1200)) u_atx_audio_ctrl (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r),
      .ws_i(ws_i), .ws_o_r(wso), .ws_oe_n_r(woe), .bclk_o_r(bck), .bclk_oe_n_r(boe),
      .spdif_frame_i(spf), .port_pin1_i(port_pin1_i), .direct_data_i(direct_data_i),
      .ssel_i(ssel_i), .mclk_o_r(mclk), .rf_en_o_r(rf_en), .tx_pd_o_r(tx_pd),
      .spdif_sel_o_r(spdif_sel), .direct_data_o_r(dd_o), .wake_o_r(wake),
      .reconfig_o_r(reconf), .act_scale_o_r(a_sc), .act_fund_o_r(a_fd),
      .comp_en_o_r(comp_en), .samp_i(samp_i), .samp_vld_i(samp_vld_i),
      .pkt_start_i(pkt_start_i), .pkt_peak_i(pkt_peak_i), .samp_o_r(s_o),
      .samp_vld_o_r(s_vld), .shift_o_r(sh_o));
   atx_src_model u_atx_src_model (.half_bits(half), .spdif_on(spf_on), .ws_o(ws_i),
      .frame_o(spf));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, well above the planned run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic int sh(input logic [23:0] p);
      for (int j = 0; j < 8; j++)
         if (p < (24'h008000 << j))
            return j;
      return 8;
   endfunction
   task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] sv);
      n_checks++;
      if (sv !== ev)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, ev, sv);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk("rdata", v, rdata_r);
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      {rst_n, wr_en, rd_en, samp_vld_i, pkt_start_i, port_pin1_i, ssel_i} = 7'h00;
      addr = 7'h00;
      wdata = 8'h00;
      half = 8'h00;
      samp_i = 24'h0;
      pkt_peak_i = 24'h0;
      direct_data_i = 3'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(7'h01, 8'h00);
      rd(7'h51, 8'h00);
      rd(7'h5a, 8'h00);
      rd(7'h02, 8'h00);
      // random mode levels, wake and reserved bits kept clear
      repeat (6)
      begin
         d = 8'(rnd()) & 8'hcf;
         wr(7'h5a, d);
         tick(2);
         chk("mode", {d[7], d[6], d[2]}, {rf_en, tx_pd, spdif_sel});
         rd(7'h5a, d);
      end
      // master clock edge count over 2000 cycles per code
      for (int c = 1; c < 4; c++)
      begin
         wr(7'h5a, 8'(c));
         n = 0;
         pm = mclk;
         repeat (2000)
         begin
            tick(1);
            n += int'(mclk && !pm);
            pm = mclk;
         end
         chk("mclk", 1, n > ex[c] - 5 && n < ex[c] + 5);
      end
      wr(7'h5a, 8'h47);
      tick(8);
      wr(7'h5a, 8'h60);
      tick(3);
      @(posedge clk) port_pin1_i <= 1'b1;
      n = 0;
      while (wake !== 1'b1 && n < 20)
      begin
         tick(1);
         n++;
      end
      chk("wake", 1, wake);
      tick(3);
      rd(7'h5a, 8'h20);
      wr(7'h5a, 8'h08);
      @(posedge clk) direct_data_i <= 3'h7;
      tick(5);
      chk("dd", 3'h3, dd_o);
      @(posedge clk) ssel_i <= 1'b1;
      tick(5);
      chk("dd", 3'h7, dd_o);
      wr(7'h54, 8'h80);
      tick(3);
      chk("oe", 0, {boe, woe});
      // master clocks at the reset rate, 48k x 0.25
      n = 0;
      k = 0;
      {pm, d[0]} = {bck, wso};
      repeat (2000)
      begin
         tick(1);
         n += int'(bck && !pm);
         k += int'(wso != d[0]);
         {pm, d[0]} = {bck, wso};
      end
      chk("bclk", 1, n > 35 && n < 41);
      chk("ws", 1, k);
      wr(7'h54, 8'h00);
      tick(3);
      chk("oe", 3, {boe, woe});
      // user rate applies only after reconfigure
      wr(7'h5a, 8'h00);
      {psc, pf} = 4'h0;
      for (int f = 0; f < 3; f++)
      begin
         sc = 2'(rnd() % 3);
         d = {1'b0, sc, 2'(f), 3'b000};
         wr(7'h01, d);
         tick(3);
         chk("hold", {psc, pf}, {a_sc, a_fd});
         wr(7'h60, 8'h10);
         tick(5);
         chk("scale", sc, a_sc);
         chk("fund", f, a_fd);
         rd(7'h01, d);
         {psc, pf} = {sc, 2'(f)};
      end
      // compressed then linear samples with random peaks
      for (int f = 1; f >= 0; f--)
      begin
         wr(7'h51, 8'(f));
         tick(3);
         chk("comp_hold", 1 - f, comp_en);
         wr(7'h60, 8'h10);
         tick(5);
         chk("comp", f, comp_en);
         for (int i = 0; i < 12; i++)
         begin
            // a new packet peak now and then; samples stay inside it
            pm = (i == 0) || rnd() % 2;
            if (pm)
               pk = 24'(rnd()) >> (1 + rnd() % 12);
            s = 24'(rnd() % (pk + 1));
            if (rnd() % 2)
               s = -s;
            k = f ? sh(pk) : 0;
            e = f ? 16'($signed(s) >>> k) : s[23:8];
            @(posedge clk);
            samp_i <= s;
            pkt_peak_i <= pk;
            samp_vld_i <= 1'b1;
            pkt_start_i <= pm;
            @(posedge clk);
            samp_vld_i <= 1'b0;
            pkt_start_i <= 1'b0;
            #1;
            chk("vld", 1, s_vld);
            chk("samp", e, s_o);
            chk("shift", k, sh_o);
         end
      end
      // slave auto detection, never 0x31 in slave mode
      wr(7'h01, 8'h01);
      wr(7'h60, 8'h10);
      for (int i = 0; i < 3; i++)
      begin
         half = 8'(hv[i]);
         tick(3500);
         chk("auto", fv[i], a_fd);
         if (fv[i] != 3)
            rd(7'h01, {3'b010, 2'(fv[i]), 3'b001});
      end
      // S/PDIF framing decides the rate; master clock stays off
      wr(7'h01, 8'h10);
      wr(7'h5a, 8'h07);
      wr(7'h60, 8'h10);
      spf_on = 1'b1;
      tick(3500);
      chk("spdif", 1, a_fd);
      chk("spdif_sc", 2, a_sc);
      chk("spdif_mclk", 0, mclk);
      print_verdict();
   end
endmodule
`default_nettype wire
